// ==== include/rapm_div_if.sv ====
/*
 Handshake between the mapper and its serial divider.
 Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface rapm_div_if #(parameter int W = 16);
	logic         start;
	logic [W-1:0] num;
	logic [W-1:0] den;
	logic [W-1:0] quot;
	logic [W-1:0] rem;
	logic         done;
	modport master (output start, num, den, input quot, rem, done);
	modport slave  (input start, num, den, output quot, rem, done);
endinterface
`default_nettype wire

// ==== include/rapm_pkg.sv ====
/*
 Constants, register map and field layouts of the access opportunity mapper.
 Assumes a 125 MHz system clock; durations are kept in units of 1/960 ms.
*/
package rapm_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] A_CFG      = 8'h00;
	localparam logic [7:0] A_TBL_ADDR = 8'h04;
	localparam logic [7:0] A_TBL_DATA = 8'h08;
	localparam logic [7:0] A_SLOTS    = 8'h0C;
	localparam logic [7:0] A_FREQ     = 8'h10;
	localparam logic [7:0] A_CMD      = 8'h14;
	localparam logic [7:0] A_STAT     = 8'h18;
	localparam logic [7:0] A_RES_T    = 8'h1C;
	localparam logic [7:0] A_RES_K    = 8'h20;
	localparam logic [7:0] A_SEQ      = 8'h24;
	localparam logic [7:0] A_SEQ_RES  = 8'h28;
	localparam logic [7:0] A_SIG      = 8'h2C;
	localparam logic [7:0] A_K0       = 8'h30;
	localparam logic [7:0] A_BURST    = 8'h34;
	localparam logic [7:0] A_DUR0     = 8'h40;
	localparam int         NUM_FMT    = 5;
	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef struct packed {logic [18:0] rsv; logic [3:0] ver; logic [5:0] dens2; logic [2:0] fmt;} rapm_tbl_t;
	typedef struct packed {logic [15:0] rsv; logic [7:0] n_hf1; logic [7:0] n_hf0;} rapm_slots_t;
	typedef struct packed {logic [9:0] rsv; logic [7:0] n_pru; logic [6:0] nru; logic [6:0] kbase;} rapm_freq_t;
	typedef struct packed {logic [23:0] rsv; logic [2:0] f; logic [4:0] d;} rapm_cmd_t;
	typedef struct packed {logic [5:0] rsv; logic [9:0] per_root; logic [9:0] u0; logic [5:0] p;} rapm_seq_t;
	typedef struct packed {logic [4:0] rsv; logic [10:0] seq; logic [4:0] rsv2; logic [10:0] guard;} rapm_dur_t;
	// ------------------------------------------------------------
	// Timing, in 1/960 ms; the lead in ns and clock cycles
	// ------------------------------------------------------------
	localparam logic [15:0] UNITS_PER_MS = 16'h03C0;
	localparam logic [10:0] GUARD_F0 = 11'h063;
	localparam logic [10:0] GUARD_F1 = 11'h291;
	localparam logic [10:0] GUARD_F3 = 11'h249;
	localparam logic [10:0] GUARD_F4 = 11'h00E;
	localparam logic [10:0] SEQ_F01  = 11'h300;
	localparam logic [10:0] SEQ_F23  = 11'h600;
	localparam logic [10:0] SEQ_F4   = 11'h080;
	localparam int LEAD_NS  = 166670;
	localparam int CLK_NS   = 8;
	localparam int LEAD_CYC = LEAD_NS / CLK_NS;
	// ------------------------------------------------------------
	// Sequence and burst constants
	// ------------------------------------------------------------
	localparam logic [2:0]  FMT_SHORT      = 3'h4;
	localparam logic [5:0]  DENS2_LIMIT    = 6'h08;
	localparam logic [15:0] RB_SPAN        = 16'h0006;
	localparam logic [9:0]  NZC_LONG       = 10'h347;
	localparam logic [9:0]  NZC_SHORT      = 10'h08B;
	localparam logic [2:0]  PHI_LONG       = 3'h7;
	localparam logic [2:0]  PHI_SHORT      = 3'h2;
	localparam int          SCS_LONG_HZ    = 1250;
	localparam int          SCS_SHORT_HZ   = 7500;
	localparam logic [6:0]  NUM_PREAMBLES  = 7'h40;
	localparam logic [1:0]  TIMING_BLOCKS  = 2'h3;
	localparam logic [4:0]  TIMING_SYMS    = 5'h10;
	localparam logic [1:0]  CTRL_CRC_UNITS = 2'h1;
	localparam logic [15:0] NULL_SYM       = 16'h0000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DL   = 3'b001,
		ST_DH0  = 3'b010,
		ST_DH1  = 3'b011,
		ST_DM   = 3'b100,
		ST_FIN  = 3'b101,
		ST_DSEQ = 3'b110
	} rapm_state_t;
endpackage

// ==== tb/rapm_bs_model.sv ====
/*
 Receiving side of the mapper: counts accepted and refused opportunities.
 Assumes the mapper clock; pulses last one cycle, so counting never misses one.
*/
`timescale 1ns/100ps
`default_nettype none
module rapm_station_model
(
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	input  wire logic opp_valid_in,
	input  wire logic opp_err_in,
	output var  int   n_ok_out,
	output var  int   n_err_out
);
	// ------------------------------------------------------------
	// Pulse counters
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			n_ok_out  <= 0;
			n_err_out <= 0;
		end
		else
		begin
			n_ok_out  <= n_ok_out + int'(opp_valid_in);
			n_err_out <= n_err_out + int'(opp_err_in);
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench of the access opportunity mapper.
 Assumes the one-cycle register bus of the mapper and a 125 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top import rapm_pkg::*;;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int LEAD = 100;
	logic        sys_clk_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic [7:0]  addr_in    = 8'h00;
	logic [31:0] wdata_in   = 32'h0;
	logic        wr_in      = 1'b0;
	logic        rd_in      = 1'b0;
	logic [31:0] rdata_out;
	logic        opp_valid_out;
	logic        opp_err_out;
	logic [1:0]  t0_out;
	logic        t1_out;
	logic [7:0]  t2_out;
	logic [6:0]  k_out;
	logic [15:0] start_lead_out;
	int          n_ok;
	int          n_err;
	int          n_mismatch = 0;
	int          checked    = 0;
	// Durations in 1/960 ms; entry 0 is rewritten in the second batch
	int          grd[5]     = '{99, 657, 657, 585, 14};
	int          sq[5]      = '{768, 768, 1536, 1536, 128};

	rapm_top #(.LEAD_CYCLES(LEAD)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.opp_valid_out(opp_valid_out), .opp_err_out(opp_err_out), .t0_out(t0_out), .t1_out(t1_out),
		.t2_out(t2_out), .k_out(k_out), .start_lead_out(start_lead_out));
	rapm_station_model station (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .opp_valid_in(opp_valid_out),
		.opp_err_in(opp_err_out), .n_ok_out(n_ok), .n_err_out(n_err));

	initial
	begin
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge sys_clk_in);
		wr_in    <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge sys_clk_in);
		rd_in   <= 1'b0;
		@(posedge sys_clk_in);
		v = rdata_out;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask
	task automatic give_verdict;
		$display("Counts: %0d comparisons, %0d mismatches", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Expected opportunity: {err, t0, t1, t2, k}
	// ------------------------------------------------------------
	function automatic logic [18:0] model(input rapm_tbl_t e, input int d, input int f, input int h0,
		input int h1, input int nru, input int kb);
		int L, cd, n, m, t2, k, t0;
		cd = (e.dens2 + 1) / 2;
		if (e.fmt > 3'h4 || d >= cd)
			return 19'h40000;
		L  = (grd[e.fmt] + sq[e.fmt] + 959) / 960;
		n  = e.ver * cd + d;
		m  = n / (1 + e.dens2 % 2);
		// Format 0 keeps the raw index only while dens2 is below eight
		if (e.fmt != 3'h0 || e.dens2 >= 6'h08)
			m = m % (h0 / L + h1 / L);
		t2 = ((m % 2) ? h1 : h0) - (m / 2 + 1) * L;
		t0 = (e.dens2 % 2) ? 1 + n % 2 : 0;
		if (e.fmt == FMT_SHORT)
			k = (m % 2) ? nru - kb - 6 - 6 * f : kb + 6 * f;
		else
			k = (f % 2) ? nru - 6 - kb - 6 * (f / 2) : kb + 6 * (f / 2);
		return {t2 < 0, t0[1:0], m[0], t2[7:0], k[6:0]};
	endfunction
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic opp_case(input rapm_tbl_t e, input int d, input int f);
		int h0, h1, nru, kb, np, o0, e0, ld;
		logic [18:0] x;
		logic [5:0] idx;
		h0  = $urandom_range(15, 6);
		h1  = $urandom_range(15, 6);
		nru = $urandom_range(60, 40);
		kb  = $urandom_range(10, 0);
		np  = $urandom_range(255, 0);
		idx = 6'($urandom);
		ld  = (e.fmt == FMT_SHORT) ? LEAD : 0;
		wr(A_TBL_ADDR, {26'h0, idx});
		wr(A_TBL_DATA, e);
		wr(A_CFG, {26'h0, idx});
		wr(A_SLOTS, {16'h0, h1[7:0], h0[7:0]});
		wr(A_FREQ, {10'h0, np[7:0], nru[6:0], kb[6:0]});
		x  = model(e, d, f, h0, h1, nru, kb);
		o0 = n_ok;
		e0 = n_err;
		wr(A_CMD, {24'h0, f[2:0], d[4:0]});
		// Second command lands while busy and must be dropped
		wr(A_CMD, {24'h0, ~f[2:0], ~d[4:0]});
		for (int i = 0; i < 300 && n_ok == o0 && n_err == e0; i++)
			@(posedge sys_clk_in);
		chk("answer", x[18] ? 2 : 1, (n_err > e0) ? 2 : 32'(n_ok > o0));
		chk_rd("cmd", A_CMD, {24'h0, f[2:0], d[4:0]});
		chk_rd("k0", A_K0, 32'(12 * np - 6 * nru));
		if (!x[18])
		begin
			chk("ports", 32'(x[17:0]), 32'({t0_out, t1_out, t2_out, k_out}));
			chk("lead", ld, 32'(start_lead_out));
			chk_rd("res_t", A_RES_T, {16'h0, x[14:7], 5'h0, x[15], x[17:16]});
			chk_rd("res_k", A_RES_K, {9'h0, ld[15:0], x[6:0]});
			chk_rd("sig", A_SIG, ld ? 32'h0001208B : 32'h00067347);
		end
	endtask
	task automatic seq_case(input int p, input int u0, input int pr);
		logic [31:0] v;
		wr(A_SEQ, {6'h0, pr[9:0], u0[9:0], p[5:0]});
		for (int i = 0; i < 100; i++)
		begin
			rd(A_STAT, v);
			if (v[0] === 1'b0)
				break;
		end
		chk_rd("seq_res", A_SEQ_RES, {6'h0, 10'(p % pr), 6'h0, 10'(u0 + p / pr)});
	endtask

	initial
	begin
		rapm_tbl_t e;
		int cd;
		void'($urandom(32'h04F8E1AE));
		repeat (16) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		for (int i = 0; i < 5; i++)
			chk_rd("dur", A_DUR0 + 8'(4 * i), {5'h0, 11'(sq[i]), 5'h0, 11'(grd[i])});
		wr(A_BURST, 32'h00000005);
		chk_rd("burst", A_BURST, 32'h00004075);
		chk_rd("unmapped", 8'hFC, 32'h0);
		$display("Test reset values done");
		for (int b = 0; b < 2; b++)
		begin
			if (b == 1)
			begin
				// A longer guard pushes format 0 to two slots
				wr(A_DUR0, {5'h0, 11'h300, 5'h0, 11'h0C1});
				grd[0] = 193;
				chk_rd("dur_rw", A_DUR0, {5'h0, 11'h300, 5'h0, 11'h0C1});
			end
			for (int i = 0; i < 40; i++)
			begin
				e       = '0;
				e.fmt   = (i < 2) ? 3'h0 : (i < 8) ? 3'(i - 2) : 3'($urandom_range(5, 0));
				e.dens2 = (i < 2) ? 6'(7 + i) : 6'($urandom_range(16, 1));
				e.ver   = 4'($urandom_range(3, 0));
				cd      = (e.dens2 + 1) / 2;
				opp_case(e, (i % 8 == 7) ? cd : $urandom_range(cd - 1, 0), $urandom_range(3, 0));
			end
			$display("Test opportunity batch %0d done", b);
		end
		seq_case(63, 0, 64);
		seq_case(63, 5, 1);
		for (int i = 0; i < 10; i++)
			seq_case($urandom_range(63, 0), $urandom_range(800, 0), $urandom_range(40, 1));
		$display("Test preamble select done");
		give_verdict();
	end

	initial
	begin
		#(8 * 60000);
		n_mismatch++;
		$display("ERROR watchdog expected finish seen hang");
		give_verdict();
	end
endmodule
`default_nettype wire

// ==== verilog/rapm_div.sv ====
/*
 Serial restoring divider, one quotient bit per clock.
 Assumes start only while idle and a nonzero divisor.
*/
`timescale 1ns/100ps
`default_nettype none
module rapm_div
	import rapm_pkg::*;
#(
	parameter int W = 16
)
(
	input  wire logic  sys_clk_in,
	input  wire logic  rst_in,
	rapm_div_if.slave  dv
);
	logic [W-1:0] q_r;
	logic [W-1:0] r_r;
	logic [W-1:0] d_r;
	logic [W-1:0] n_r;
	logic [5:0]   cnt_r;
	logic         done_r;
	logic [W:0]   tr;

	assign tr      = {r_r, q_r[W-1]};
	assign dv.quot = q_r;
	assign dv.rem  = r_r;
	// A result still in flight from a dropped command must not meet a new start
	assign dv.done = done_r && !dv.start;

	// ------------------------------------------------------------
	// Iteration
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			q_r    <= '0;
			r_r    <= '0;
			d_r    <= '0;
			n_r    <= '0;
			cnt_r  <= '0;
			done_r <= 1'b0;
		end
		else if (dv.start)
		begin
			q_r    <= dv.num;
			n_r    <= dv.num;
			r_r    <= '0;
			d_r    <= dv.den;
			cnt_r  <= 6'(W);
			done_r <= 1'b0;
		end
		else if (cnt_r != '0)
		begin
			if (tr >= {1'b0, d_r})
			begin
				r_r <= W'(tr - {1'b0, d_r});
				q_r <= {q_r[W-2:0], 1'b1};
			end
			else
			begin
				r_r <= tr[W-1:0];
				q_r <= {q_r[W-2:0], 1'b0};
			end
			cnt_r  <= cnt_r - 6'h01;
			done_r <= (cnt_r == 6'h01);
		end
		else
			done_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_div_exact: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		done_r |-> (2*W)'(q_r) * (2*W)'(d_r) + (2*W)'(r_r) == (2*W)'(n_r) && r_r < d_r)
		else $error("divider result inconsistent");
	chk_div_latency: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		done_r |-> $past(dv.start, 17))
		else $error("divider latency wrong");
endmodule
`default_nettype wire

// ==== verilog/rapm_top.sv ====
/*
 Random access opportunity mapper: picks format, time and frequency location
 of each access opportunity and the root and shift of each cell preamble.
 Assumes a register master on the same clock that never issues both strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module rapm_top
	import rapm_pkg::*;
#(
	parameter int LEAD_CYCLES = LEAD_CYC,
	parameter int SUBC_PER_RU = 12,
	parameter int DATA_SCS_HZ = 15000
)
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [31:0] rdata_out,
	output var  logic        opp_valid_out,
	output var  logic        opp_err_out,
	output var  logic [1:0]  t0_out,
	output var  logic        t1_out,
	output var  logic [7:0]  t2_out,
	output var  logic [6:0]  k_out,
	output var  logic [15:0] start_lead_out
);
	localparam logic [4:0] K_LONG  = 5'(DATA_SCS_HZ / SCS_LONG_HZ);
	localparam logic [4:0] K_SHORT = 5'(DATA_SCS_HZ / SCS_SHORT_HZ);

	rapm_tbl_t   tbl_mem [64];
	rapm_dur_t   dur_r [NUM_FMT];
	rapm_tbl_t   ent_r;
	rapm_slots_t slots_r;
	rapm_freq_t  freq_r;
	rapm_cmd_t   cmd_r;
	rapm_seq_t   seq_r;
	rapm_state_t st_r;
	logic [5:0]  cfg_idx_r;
	logic [5:0]  tbl_addr_r;
	logic [3:0]  core_seq_r;
	logic [15:0] l_r;
	logic [15:0] tot_r;
	logic [15:0] m_r;
	logic [15:0] mnum;
	logic [15:0] mbase;
	logic [5:0]  ceil_d;
	logic        dstart_r;
	logic        err_r;
	logic [9:0]  root_r;
	logic [9:0]  shift_r;
	logic [15:0] nsel;
	logic [15:0] t2_full;
	logic [15:0] koff;
	logic [15:0] k_full;
	logic        k_bad;
	logic        is_short;
	logic        wr_cmd;
	logic        wr_seq;
	logic [31:0] rdata_nxt;
	logic signed [17:0] k0;

	rapm_div_if #(.W(16)) dv ();

	rapm_div #(.W(16)) u_div (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.dv         (dv)
	);

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	assign wr_cmd = wr_in && addr_in == A_CMD && st_r == ST_IDLE;
	assign wr_seq = wr_in && addr_in == A_SEQ && st_r == ST_IDLE;

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cfg_idx_r  <= '0;
			tbl_addr_r <= '0;
			slots_r    <= '0;
			freq_r     <= '0;
			cmd_r      <= '0;
			seq_r      <= '0;
			core_seq_r <= '0;
		end
		else if (wr_in)
		begin
			if (addr_in == A_CFG)
				cfg_idx_r <= wdata_in[5:0];
			if (addr_in == A_TBL_ADDR)
				tbl_addr_r <= wdata_in[5:0];
			if (addr_in == A_TBL_DATA)
				tbl_addr_r <= tbl_addr_r + 6'h01;
			if (addr_in == A_SLOTS)
				slots_r <= rapm_slots_t'(wdata_in);
			if (addr_in == A_FREQ)
				freq_r <= rapm_freq_t'(wdata_in);
			if (wr_cmd)
				cmd_r <= rapm_cmd_t'(wdata_in);
			if (wr_seq)
				seq_r <= rapm_seq_t'(wdata_in);
			if (addr_in == A_BURST)
				core_seq_r <= wdata_in[3:0];
		end
	end

	// Table memory has no reset; software loads it before the first command
	always_ff @(posedge sys_clk_in)
	begin
		if (wr_in && addr_in == A_TBL_DATA)
			tbl_mem[tbl_addr_r] <= rapm_tbl_t'(wdata_in);
	end

	// Middle formats carry disputed guard values, so all durations are writable
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dur_r[0] <= '{rsv: '0, seq: SEQ_F01, rsv2: '0, guard: GUARD_F0};
			dur_r[1] <= '{rsv: '0, seq: SEQ_F01, rsv2: '0, guard: GUARD_F1};
			dur_r[2] <= '{rsv: '0, seq: SEQ_F23, rsv2: '0, guard: GUARD_F1};
			dur_r[3] <= '{rsv: '0, seq: SEQ_F23, rsv2: '0, guard: GUARD_F3};
			dur_r[4] <= '{rsv: '0, seq: SEQ_F4, rsv2: '0, guard: GUARD_F4};
		end
		else
		begin
			for (int i = 0; i < NUM_FMT; i++)
			begin
				if (wr_in && addr_in == A_DUR0 + 8'(4 * i))
					dur_r[i] <= rapm_dur_t'(wdata_in);
			end
		end
	end

	// ------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------
	assign is_short = ent_r.fmt == FMT_SHORT;
	assign ceil_d   = (ent_r.dens2 + 6'h01) >> 1;
	assign mbase    = 16'(ent_r.ver * ceil_d) + 16'(cmd_r.d);
	assign mnum     = ent_r.dens2[0] ? (mbase >> 1) : mbase;
	assign nsel     = m_r[0] ? 16'(slots_r.n_hf1) : 16'(slots_r.n_hf0);
	assign t2_full  = 16'(((m_r >> 1) + 16'h0001) * l_r);
	assign koff     = is_short ? 16'(RB_SPAN * 16'(cmd_r.f)) : 16'(RB_SPAN * 16'(cmd_r.f >> 1));
	assign k0       = 18'(SUBC_PER_RU * int'(freq_r.n_pru)) - 18'((SUBC_PER_RU * int'(freq_r.nru)) / 2);

	always_comb
	begin
		if (is_short ? !m_r[0] : !cmd_r.f[0])
			k_full = 16'(freq_r.kbase) + koff;
		else
			k_full = 16'(freq_r.nru) - RB_SPAN - 16'(freq_r.kbase) - koff;
		k_bad = (16'(freq_r.kbase) + koff + RB_SPAN) > 16'(freq_r.nru);
	end

	always_comb
	begin
		dv.num = '0;
		dv.den = '0;
		unique case (st_r)
			ST_DL:
			begin
				// A format with no duration entry divides zero, keeping the divider defined
				if (ent_r.fmt <= FMT_SHORT)
					dv.num = 16'(dur_r[ent_r.fmt].guard) + 16'(dur_r[ent_r.fmt].seq);
				dv.den = UNITS_PER_MS;
			end
			ST_DH0:
			begin
				dv.num = 16'(slots_r.n_hf0);
				dv.den = l_r;
			end
			ST_DH1:
			begin
				dv.num = 16'(slots_r.n_hf1);
				dv.den = l_r;
			end
			ST_DM:
			begin
				dv.num = mnum;
				dv.den = tot_r;
			end
			ST_DSEQ:
			begin
				dv.num = 16'(seq_r.p);
				dv.den = 16'(seq_r.per_root);
			end
			ST_IDLE, ST_FIN:
			begin
				dv.num = '0;
				dv.den = '0;
			end
		endcase
	end
	assign dv.start = dstart_r;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r     <= ST_IDLE;
			dstart_r <= 1'b0;
			ent_r    <= '0;
			l_r      <= '0;
			tot_r    <= '0;
			m_r      <= '0;
			err_r    <= 1'b0;
			root_r   <= '0;
			shift_r  <= '0;
		end
		else
		begin
			dstart_r <= 1'b0;
			unique case (st_r)
				ST_IDLE:
				begin
					if (wr_cmd)
					begin
						ent_r    <= tbl_mem[cfg_idx_r];
						st_r     <= ST_DL;
						dstart_r <= 1'b1;
						err_r    <= 1'b0;
					end
					else if (wr_seq)
					begin
						if (wdata_in[25:16] == '0)
							err_r <= 1'b1;
						else
						begin
							st_r     <= ST_DSEQ;
							dstart_r <= 1'b1;
							err_r    <= 1'b0;
						end
					end
				end
				ST_DL:
				begin
					if (ent_r.fmt > FMT_SHORT || 6'(cmd_r.d) >= ceil_d)
					begin
						err_r <= 1'b1;
						st_r  <= ST_FIN;
					end
					else if (dv.done)
					begin
						l_r      <= dv.quot + 16'(dv.rem != '0);
						st_r     <= ST_DH0;
						dstart_r <= 1'b1;
					end
				end
				ST_DH0:
				begin
					if (dv.done)
					begin
						tot_r    <= dv.quot;
						st_r     <= ST_DH1;
						dstart_r <= 1'b1;
					end
				end
				ST_DH1:
				begin
					if (dv.done)
					begin
						tot_r <= tot_r + dv.quot;
						if (ent_r.fmt == '0 && ent_r.dens2 < DENS2_LIMIT)
						begin
							m_r  <= mnum;
							st_r <= ST_FIN;
						end
						else if (tot_r + dv.quot == '0)
						begin
							err_r <= 1'b1;
							st_r  <= ST_FIN;
						end
						else
						begin
							tot_r    <= tot_r + dv.quot;
							st_r     <= ST_DM;
							dstart_r <= 1'b1;
						end
					end
				end
				ST_DM:
				begin
					if (dv.done)
					begin
						m_r  <= dv.rem;
						st_r <= ST_FIN;
					end
				end
				ST_FIN:
				begin
					if (nsel < t2_full || k_bad)
						err_r <= 1'b1;
					st_r <= ST_IDLE;
				end
				ST_DSEQ:
				begin
					if (dv.done)
					begin
						root_r  <= seq_r.u0 + dv.quot[9:0];
						shift_r <= dv.rem[9:0];
						st_r    <= ST_IDLE;
					end
				end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Opportunity outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			opp_valid_out  <= 1'b0;
			opp_err_out    <= 1'b0;
			t0_out         <= '0;
			t1_out         <= 1'b0;
			t2_out         <= '0;
			k_out          <= '0;
			start_lead_out <= '0;
		end
		else
		begin
			opp_valid_out <= st_r == ST_FIN && !err_r && nsel >= t2_full && !k_bad;
			opp_err_out   <= st_r == ST_FIN && (err_r || nsel < t2_full || k_bad);
			if (st_r == ST_FIN)
			begin
				t0_out         <= ent_r.dens2[0] ? 2'h1 + 2'(mbase[0]) : 2'h0;
				t1_out         <= m_r[0];
				t2_out         <= 8'(nsel - t2_full);
				k_out          <= 7'(k_full);
				start_lead_out <= is_short ? 16'(LEAD_CYCLES) : 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = '0;
		if (rd_in)
		begin
			unique case (addr_in)
				A_CFG:      rdata_nxt = {26'h0, cfg_idx_r};
				A_TBL_ADDR: rdata_nxt = {26'h0, tbl_addr_r};
				A_SLOTS:    rdata_nxt = slots_r;
				A_FREQ:     rdata_nxt = freq_r;
				A_CMD:      rdata_nxt = cmd_r;
				A_STAT:     rdata_nxt = {16'h0, l_r[7:0], 1'b0, st_r, 3'(err_r), st_r != ST_IDLE};
				A_RES_T:    rdata_nxt = {16'h0, t2_out, 5'h0, t1_out, t0_out};
				A_RES_K:    rdata_nxt = {9'h0, start_lead_out, k_out};
				A_SEQ:      rdata_nxt = seq_r;
				A_SEQ_RES:  rdata_nxt = {6'h0, shift_r, 6'h0, root_r};
				A_SIG:      rdata_nxt = is_short ? {12'h0, K_SHORT, PHI_SHORT, 2'h0, NZC_SHORT}
				                                 : {12'h0, K_LONG, PHI_LONG, 2'h0, NZC_LONG};
				A_K0:       rdata_nxt = 32'(k0);
				A_BURST:    rdata_nxt = {NULL_SYM, 1'b0, NUM_PREAMBLES, CTRL_CRC_UNITS, TIMING_BLOCKS, core_seq_r};
				default:
				begin
					for (int i = 0; i < NUM_FMT; i++)
					begin
						if (addr_in == A_DUR0 + 8'(4 * i))
							rdata_nxt = dur_r[i];
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_out <= '0;
		else
			rdata_out <= rdata_nxt;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	chk_fmt0_defaults: assert property ($fell(rst_in) |-> dur_r[0].guard == GUARD_F0 && dur_r[1].guard == GUARD_F1)
		else $error("format 0/1 durations wrong after reset");
	chk_fmt4_defaults: assert property ($fell(rst_in) |-> dur_r[4].guard == GUARD_F4 && dur_r[4].seq == SEQ_F4)
		else $error("format 4 durations wrong after reset");
	chk_valid_err_excl: assert property (!(opp_valid_out && opp_err_out))
		else $error("valid and error together");
	chk_slot_ceiling: assert property (opp_valid_out |->
		l_r * UNITS_PER_MS >= 16'(dur_r[ent_r.fmt].guard) + 16'(dur_r[ent_r.fmt].seq)
		&& (l_r - 16'h0001) * UNITS_PER_MS < 16'(dur_r[ent_r.fmt].guard) + 16'(dur_r[ent_r.fmt].seq))
		else $error("slot length not a ceiling");
	chk_half_parity: assert property (opp_valid_out |-> t1_out == m_r[0])
		else $error("half frame field mismatch");
	chk_frame_every: assert property (opp_valid_out && !ent_r.dens2[0] |-> t0_out == 2'h0)
		else $error("frame field nonzero for whole density");
	chk_lead_short: assert property (opp_valid_out && is_short |-> start_lead_out == 16'(LEAD_CYCLES))
		else $error("format 4 lead wrong");
	chk_lead_long: assert property (opp_valid_out && !is_short |-> start_lead_out == 16'h0000)
		else $error("long format not slot aligned");
	chk_block_span: assert property (opp_valid_out |-> 16'(k_out) + RB_SPAN <= 16'(freq_r.nru))
		else $error("six block span exceeds band");
	chk_cmd_busy: assert property (st_r != ST_IDLE && wr_in && addr_in == A_CMD |=> $stable(cmd_r))
		else $error("command taken while busy");
endmodule
`default_nettype wire
